// ==== inc/mrb_pkg.sv ====
`default_nettype none
package mrb_pkg;
  // ==========================================================
  // setting encodings
  typedef enum logic [1:0] {
    FLT_NONE,
    FLT_ONE,
    FLT_TWO
  } mrb_filter_t;
  typedef enum logic [1:0] {
    STOP_DECEL1,
    STOP_COAST2,
    STOP_REGEN3
  } mrb_stop_t;
  // ==========================================================
  // reset values, limits and holding angle
  localparam mrb_filter_t FILTER_RST = FLT_NONE;
  localparam mrb_stop_t STOP_RST = STOP_DECEL1;
  localparam logic DIR_CCW_RST = 1'b0;
  localparam logic MODE_TWO_WIRE_RST = 1'b0;
  localparam logic [8:0] WIDTH_RST = 9'h0c8;
  localparam logic [8:0] WIDTH_MIN = 9'h001;
  localparam logic [8:0] WIDTH_MAX = 9'h190;
  localparam logic HOLD_EN_RST = 1'b0;
  localparam logic signed [7:0] HOLD_LIM_RST = -8'sd1;
  localparam logic [7:0] HOLD_LIM_MAX = 8'h32;
  localparam logic [7:0] HOLD_ANGLE = 8'h0f;
  // ==========================================================
  // grouped settings
  typedef struct packed {
    mrb_filter_t filter;
    mrb_stop_t stop_mode;
    logic dir_ccw;
    logic two_wire;
    logic hold_en;
  } mrb_cfg_t;
endpackage
`default_nettype wire

// ==== design/mrb_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module mrb_ctrl
  import mrb_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [1:0] SET_FILTER,
  input wire logic [1:0] SET_STOP_MODE,
  input wire logic SET_DIR_CCW,
  input wire logic SET_TWO_WIRE,
  input wire logic [8:0] SET_WIDTH,
  input wire logic SET_HOLD_EN,
  input wire logic signed [7:0] SET_HOLD_LIM,
  input wire logic CONFIGURE,
  input wire logic FORWARD_RUN_INPUT,
  input wire logic REVERSE_RUN_INPUT,
  input wire logic START_INPUT,
  input wire logic RUN_DIRECTION_INPUT,
  input wire logic [11:0] CMD_SPEED,
  input wire logic [11:0] ACT_SPEED,
  input wire logic [7:0] OPDATA_TRQ_LIM,
  input wire logic [7:0] SHAFT_DISP,
  input wire logic STOPPED,
  input wire logic ALARM,
  output logic RUN,
  output logic DIR_CCW,
  output logic [1:0] FILTER,
  output logic [1:0] STOP_MODE,
  output logic SPEED_REACHED_OUTPUT,
  output logic HOLD_ACTIVE,
  output logic [7:0] HOLD_LIMIT
);
  // ==========================================================
  // input synchronisers: three stages, change on 2nd==3rd
  logic [3:0] s1, s2, s3, pin;
  logic [3:0] next_pin;
  always_comb begin
    next_pin = pin;
    for (int i = 0; i < 4; i++) begin
      if (s2[i] == s3[i]) begin
        next_pin[i] = s3[i];
      end
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
      pin <= 4'h0;
    end else begin
      s1 <= {RUN_DIRECTION_INPUT, START_INPUT, REVERSE_RUN_INPUT,
             FORWARD_RUN_INPUT};
      s2 <= s1;
      s3 <= s2;
      pin <= next_pin;
    end
  end
  // ==========================================================
  // active settings
  mrb_cfg_t cfg, next_cfg;
  logic [8:0] width, next_width;
  logic signed [7:0] hold_lim, next_hold_lim;
  always_comb begin
    next_cfg = cfg;
    next_width = width;
    next_hold_lim = hold_lim;
    // class A: width and holding limit follow at once
    if (SET_WIDTH >= WIDTH_MIN && SET_WIDTH <= WIDTH_MAX) begin
      next_width = SET_WIDTH;
    end
    // out of range values are ignored, last good value kept
    if (SET_HOLD_LIM >= HOLD_LIM_RST &&
        SET_HOLD_LIM <= $signed(HOLD_LIM_MAX)) begin
      next_hold_lim = SET_HOLD_LIM;
    end
    // class B: filter and stop mode only while stopped
    if (STOPPED) begin
      if (SET_FILTER <= 2'(FLT_TWO)) begin
        next_cfg.filter = mrb_filter_t'(SET_FILTER);
      end
      if (SET_STOP_MODE <= 2'(STOP_REGEN3)) begin
        next_cfg.stop_mode = mrb_stop_t'(SET_STOP_MODE);
      end
    end
    // class C: direction, wiring mode, holding enable
    if (CONFIGURE) begin
      next_cfg.dir_ccw = SET_DIR_CCW;
      next_cfg.two_wire = SET_TWO_WIRE;
      next_cfg.hold_en = SET_HOLD_EN;
    end
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg <= '{FILTER_RST, STOP_RST, DIR_CCW_RST, MODE_TWO_WIRE_RST,
               HOLD_EN_RST};
      width <= WIDTH_RST;
      hold_lim <= HOLD_LIM_RST;
    end else begin
      cfg <= next_cfg;
      width <= next_width;
      hold_lim <= next_hold_lim;
    end
  end
  // ==========================================================
  // run decode and outputs
  logic next_run, next_dir, next_reached, next_hold;
  logic [7:0] next_limit;
  logic [11:0] diff;
  always_comb begin
    next_run = 1'b0;
    next_dir = 1'b0;
    if (cfg.two_wire) begin
      // both inputs on counts as stop
      next_run = pin[0] ^ pin[1];
      next_dir = pin[0] ? cfg.dir_ccw : !cfg.dir_ccw;
    end else begin
      next_run = pin[2];
      next_dir = pin[3] ? cfg.dir_ccw : !cfg.dir_ccw;
    end
    diff = (ACT_SPEED > CMD_SPEED) ? ACT_SPEED - CMD_SPEED
                                   : CMD_SPEED - ACT_SPEED;
    next_reached = (diff <= {3'h0, width});
    // holding limit: opdata clamped to 50 percent, else direct
    if (hold_lim < 0) begin
      next_limit = (OPDATA_TRQ_LIM > HOLD_LIM_MAX) ? HOLD_LIM_MAX
                                                   : OPDATA_TRQ_LIM;
    end else begin
      next_limit = hold_lim[7:0];
    end
    next_hold = cfg.hold_en && STOPPED && !ALARM &&
                (SHAFT_DISP >= HOLD_ANGLE);
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RUN <= 1'b0;
      DIR_CCW <= 1'b0;
      SPEED_REACHED_OUTPUT <= 1'b0;
      HOLD_ACTIVE <= 1'b0;
      HOLD_LIMIT <= 8'h00;
      FILTER <= 2'h0;
      STOP_MODE <= 2'h0;
    end else begin
      RUN <= next_run;
      DIR_CCW <= next_dir;
      SPEED_REACHED_OUTPUT <= next_reached;
      HOLD_ACTIVE <= next_hold;
      HOLD_LIMIT <= next_limit;
      // ramp filtering lengthens ramps in the drive core
      FILTER <= 2'(cfg.filter);
      // coast mode: core follows decel time if it is longer
      STOP_MODE <= 2'(cfg.stop_mode);
    end
  end
  // ==========================================================
  // checks
  alarm_drops_hold_a: assert property (
    @(posedge CLK) disable iff (!RST_N) ALARM |=> !HOLD_ACTIVE)
    else $error("holding active during alarm");
  reached_window_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (diff <= {3'h0, width}) |=> SPEED_REACHED_OUTPUT)
    else $error("speed reached missing inside window");
  reached_drop_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (diff > {3'h0, width}) |=> !SPEED_REACHED_OUTPUT)
    else $error("speed reached outside window");
  hold_clamp_a: assert property (
    @(posedge CLK) disable iff (!RST_N) HOLD_LIMIT <= HOLD_LIM_MAX)
    else $error("holding limit above half rated");
  filter_stopped_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !$past(STOPPED) |-> $stable(cfg.filter))
    else $error("filter changed while running");
  dir_config_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !$past(CONFIGURE) |-> $stable(cfg.dir_ccw))
    else $error("direction changed without configure");
  hold_angle_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (SHAFT_DISP < HOLD_ANGLE) |=> !HOLD_ACTIVE)
    else $error("holding below shift angle");
  hold_enable_a: assert property (
    @(posedge CLK) disable iff (!RST_N) !cfg.hold_en |=> !HOLD_ACTIVE)
    else $error("holding while disabled");
  width_range_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    width >= WIDTH_MIN && width <= WIDTH_MAX)
    else $error("detection width out of range");
  stop_mode_hold_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !$past(STOPPED) |-> $stable(cfg.stop_mode))
    else $error("stop mode changed while running");
  both_inputs_stop_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (cfg.two_wire && pin[0] && pin[1]) |=> !RUN)
    else $error("run with both two-wire inputs on");
  width_follow_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (SET_WIDTH >= WIDTH_MIN && SET_WIDTH <= WIDTH_MAX)
    |=> width == $past(SET_WIDTH))
    else $error("detection width not taken at once");
  limit_opdata_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    (hold_lim[7] && OPDATA_TRQ_LIM <= HOLD_LIM_MAX)
    |=> HOLD_LIMIT == $past(OPDATA_TRQ_LIM))
    else $error("holding limit not from operation data");
  limit_direct_a: assert property (
    @(posedge CLK) disable iff (!RST_N)
    !hold_lim[7] |=> HOLD_LIMIT == $past(hold_lim[7:0]))
    else $error("programmed holding limit not applied");
endmodule
`default_nettype wire

// ==== verif/mrb_motor.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// motor model
module mrb_motor(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic RUN,
  input wire logic [11:0] CMD_SPEED,
  input wire logic signed [11:0] ERR,
  output logic [11:0] ACT_SPEED,
  output logic STOPPED
);
  // one-cycle lag; speed error is forced by the bench
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ACT_SPEED <= 12'h000;
      STOPPED <= 1'b1;
    end else begin
      ACT_SPEED <= 12'(CMD_SPEED + ERR);
      STOPPED <= !RUN;
    end
  end
endmodule
`default_nettype wire

// ==== verif/mrb_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// bench
module mrb_ctrl_tb;
  import mrb_pkg::*;
  logic CLK, RST_N, dcw, two, hen, cfg, forward_run_input, rev, sta, rdir, alm;
  logic run, dccw, stp, spd, hact;
  logic [1:0] sf, ssm, flt, smd;
  logic [8:0] wid;
  logic signed [7:0] hl;
  logic [11:0] cmd, act;
  logic signed [11:0] err;
  logic [7:0] opd, disp, hlim;
  int miscompares, n_compared, seed, i, d;
  mrb_ctrl mrb_ctrl_i(.CLK(CLK), .RST_N(RST_N), .SET_FILTER(sf),
    .SET_STOP_MODE(ssm), .SET_DIR_CCW(dcw), .SET_TWO_WIRE(two),
    .SET_WIDTH(wid), .SET_HOLD_EN(hen), .SET_HOLD_LIM(hl), .CONFIGURE(cfg),
    .FORWARD_RUN_INPUT(forward_run_input), .REVERSE_RUN_INPUT(rev), .START_INPUT(sta),
    .RUN_DIRECTION_INPUT(rdir), .CMD_SPEED(cmd), .ACT_SPEED(act),
    .OPDATA_TRQ_LIM(opd), .SHAFT_DISP(disp), .STOPPED(stp), .ALARM(alm),
    .RUN(run), .DIR_CCW(dccw), .FILTER(flt), .STOP_MODE(smd),
    .SPEED_REACHED_OUTPUT(spd), .HOLD_ACTIVE(hact), .HOLD_LIMIT(hlim));
  mrb_motor mrb_motor_i(.CLK(CLK), .RST_N(RST_N), .RUN(run),
    .CMD_SPEED(cmd), .ERR(err), .ACT_SPEED(act), .STOPPED(stp));
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #5;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic in_win(int c, int a, int w);
    return a >= c - w && a <= c + w;
  endfunction
  initial begin
    CLK = 0;
    forever #25 CLK = ~CLK;
  end
  // run needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge CLK);
    miscompares++;
    finish_test;
  end
  initial begin
    seed = 70715;
    {RST_N, cfg, forward_run_input, rev, sta, rdir, alm, dcw, two, hen} = 0;
    sf = 0; ssm = 0; wid = WIDTH_RST; hl = -1; cmd = 0; err = 0;
    opd = 8'h50; disp = 8'h0f;
    repeat (8) @(posedge CLK);
    #5 RST_N = 1;
    step(4);
    chk(hlim, HOLD_LIM_MAX);
    opd = 8'h1e; step(3);
    chk(hlim, 8'h1e);
    hl = 8'sd20; step(3);
    chk(hlim, 8'h14);
    hl = 8'sd51; step(3);
    chk(hlim, 8'h14);
    $display("limits done");
    // width 401 is out of range, so the first eight keep 200
    for (i = 0; i < 24; i++) begin
      wid = (i < 8) ? 9'h191 : (i < 16) ? 9'h0c8 : 9'h001;
      d = $random(seed) % ((i < 16) ? 300 : 3);
      if (i == 0) d = 200;
      if (i == 1) d = -201;
      cmd = 12'(500 + ($random(seed) & 1023));
      err = 12'(d);
      step(4);
      chk(spd, in_win(cmd, cmd + d, (i < 16) ? 200 : 1));
    end
    $display("window done");
    hen = 1; step(3);
    chk(hact, 0);
    cfg = 1; step(1); cfg = 0; step(3);
    chk(hact, 1);
    disp = 8'h0e; step(3);
    chk(hact, 0);
    disp = 8'h0f; alm = 1; step(3);
    chk(hact, 0);
    alm = 0;
    $display("hold done");
    sta = 1; rdir = 1; step(6);
    chk({run, dccw}, 2'b10);
    sf = 2'h1; ssm = 2'h2; step(4);
    chk({flt, smd}, 4'h0);
    rdir = 0; step(6);
    chk(dccw, 1);
    sta = 0; step(8);
    chk({flt, smd}, 4'h6);
    for (i = 0; i < 4; i++) begin
      ssm = 2'(i); sf = 2'(i); step(3);
      chk({flt, smd}, (i < 3) ? 4'(i * 5) : 4'ha);
    end
    $display("modes done");
    two = 1; dcw = 1; cfg = 1; step(1); cfg = 0;
    forward_run_input = 1; step(6);
    chk({run, dccw}, 2'b11);
    forward_run_input = 0; rev = 1; step(6);
    chk({run, dccw}, 2'b10);
    forward_run_input = 1; step(6);
    chk(run, 0);
    $display("wiring done");
    finish_test;
  end
endmodule
`default_nettype wire
